// File: abr_pkg.sv
package abr_pkg;
   // register byte offsets from the bridge register base
   localparam logic [7:0] ABR_OFS_WAIT_LOW = 8'h00;
   localparam logic [7:0] ABR_OFS_WAIT_HIGH = 8'h04;
   localparam logic [31:0] ABR_RST_WAIT_LOW = 32'h0040_0500;
   localparam logic [31:0] ABR_RST_WAIT_HIGH = 32'h0000_0000;
   // slot 00 is the bridge's own register window
   localparam logic [4:0] ABR_SLOT_SELF = 5'h00;
   localparam int ABR_SLOT_MSB = 16;
   localparam int ABR_SLOT_LSB = 12;
   localparam int ABR_FIELD_W = 2;
   localparam int ABR_SLOTS_PER_REG = 16;
   // wait counter value in the first cycle of the access phase
   localparam logic [1:0] ABR_BASE_WAIT = 2'h0;
   // AHB encodings
   localparam logic [1:0] ABR_HTRANS_NONSEQ = 2'h2;
   localparam logic [1:0] ABR_HSIZE_BYTE = 2'h0;
   localparam logic [1:0] ABR_HSIZE_HALF = 2'h1;
   localparam logic [1:0] ABR_HSIZE_WORD = 2'h2;
   typedef enum logic [1:0] {
      ABR_IDLE,
      ABR_SETUP,
      ABR_ACCESS
   } abr_state_t;
endpackage

// File: abr_lane.sv
`timescale 1ns/1ps
// ***********************
// byte lane steering
// ***********************
module abr_lane
   import abr_pkg::*;
(
   input wire logic [1:0] size,
   input wire logic [1:0] addr_lo,
   input wire logic [31:0] wdata_in,
   input wire logic [31:0] rdata_in,
   output logic [31:0] wdata_out,
   output logic [31:0] rdata_out,
   output logic upper_byte_active,
   output logic lower_byte_active
);
   // peripherals see narrow data in the low lanes; upper/lower
   // strobes tell a 16-bit peripheral which byte of it is live
   always_comb begin
      wdata_out = wdata_in;
      rdata_out = rdata_in;
      upper_byte_active = 1'b1;
      lower_byte_active = 1'b1;
      case (size)
         ABR_HSIZE_BYTE: begin
            wdata_out = {24'h0, wdata_in[8*addr_lo +: 8]};
            rdata_out = {4{rdata_in[7:0]}};
            upper_byte_active = addr_lo[0];
            lower_byte_active = ~addr_lo[0];
         end
         ABR_HSIZE_HALF: begin
            wdata_out = {16'h0, wdata_in[16*addr_lo[1] +: 16]};
            rdata_out = {2{rdata_in[15:0]}};
         end
         default: begin
         end
      endcase
   end
endmodule

// File: abr_bridge.sv
`timescale 1ns/1ps
// What this block does
// - AHB slave forwarding accesses to APB peripherals
// - generate APB setup and access phases
// - accept byte, half-word and word sizes
// - steer narrow data onto correct lanes
// - one select per slot, only target asserted
// - drive upper and lower byte active strobes
// - two cycles minimum, plus zero to three
// - wait field code adds that many cycles
// - low register holds slots 00 to 0F
// - high register holds slots 10 to 1F
// - reset values and offsets of wait registers
// - fixed slot to wait field mapping
// - own registers decoded from bridge base
module abr_bridge
   import abr_pkg::*;
#(
   parameter int NSLOT = 32
)(
   input wire logic clock,
   input wire logic nrst,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready_in,
   output logic hready_out,
   output logic [1:0] hresp,
   output logic [31:0] hrdata,
   output logic [NSLOT-1:0] psel,
   output logic penable,
   output logic pwrite,
   output logic [31:0] paddr,
   output logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   output logic upper_byte_active,
   output logic lower_byte_active
);
   initial begin
      if (NSLOT != 2 * ABR_SLOTS_PER_REG)
         $error("abr_bridge serves exactly 32 slots");
      if (ABR_FIELD_W * ABR_SLOTS_PER_REG != 32)
         $error("wait fields must fill one 32-bit register");
      if (ABR_SLOT_MSB - ABR_SLOT_LSB != 4)
         $error("slot number must be five bits wide");
   end

   // ***********************
   // state
   // ***********************
   abr_state_t state_r, state_nxt;
   logic [31:0] addr_r, addr_nxt;
   logic wr_r, wr_nxt;
   logic [1:0] size_r, size_nxt;
   logic [1:0] wait_r, wait_nxt;
   logic [1:0] cnt_r, cnt_nxt;
   logic [31:0] wait_low_r, wait_low_nxt;
   logic [31:0] wait_high_r, wait_high_nxt;
   logic [31:0] rdata_r, rdata_nxt;
   logic [31:0] pwdata_r, pwdata_nxt;

   logic [31:0] lane_wdata, lane_rdata, own_rdata;
   logic [4:0] slot, cur_slot;
   logic self_sel;
   logic start;
   logic [1:0] slot_wait_field;

   assign start = hsel && hready_in && htrans[1];
   assign slot = haddr[ABR_SLOT_MSB:ABR_SLOT_LSB];
   assign cur_slot = addr_r[ABR_SLOT_MSB:ABR_SLOT_LSB];
   assign self_sel = (cur_slot == ABR_SLOT_SELF);

   // field for the slot being started, latched so later writes
   // cannot stretch or shorten an access in flight
   always_comb begin
      if (slot[4])
         slot_wait_field = wait_high_r[ABR_FIELD_W*slot[3:0] +: 2];
      else
         slot_wait_field = wait_low_r[ABR_FIELD_W*slot[3:0] +: 2];
   end

   abr_lane u_lane (
      .size(size_r),
      .addr_lo(addr_r[1:0]),
      .wdata_in(hwdata),
      .rdata_in(self_sel ? own_rdata : prdata),
      .wdata_out(lane_wdata),
      .rdata_out(lane_rdata),
      .upper_byte_active(upper_byte_active),
      .lower_byte_active(lower_byte_active)
   );

   always_comb begin
      case (addr_r[7:0])
         ABR_OFS_WAIT_LOW: own_rdata = wait_low_r;
         ABR_OFS_WAIT_HIGH: own_rdata = wait_high_r;
         default: own_rdata = 32'h0;
      endcase
   end

   // ***********************
   // transfer sequencer
   // ***********************
   always_comb begin
      state_nxt = state_r;
      addr_nxt = addr_r;
      wr_nxt = wr_r;
      size_nxt = size_r;
      wait_nxt = wait_r;
      cnt_nxt = cnt_r;
      wait_low_nxt = wait_low_r;
      wait_high_nxt = wait_high_r;
      rdata_nxt = rdata_r;
      pwdata_nxt = pwdata_r;
      case (state_r)
         ABR_IDLE: begin
            if (start) begin
               addr_nxt = haddr;
               wr_nxt = hwrite;
               size_nxt = hsize[1:0];
               wait_nxt = slot_wait_field;
               cnt_nxt = ABR_BASE_WAIT;
               state_nxt = ABR_SETUP;
            end
         end
         ABR_SETUP: begin
            pwdata_nxt = lane_wdata;
            state_nxt = ABR_ACCESS;
         end
         ABR_ACCESS: begin
            if (cnt_r == wait_r) begin
               rdata_nxt = lane_rdata;
               if (wr_r && self_sel && size_r == ABR_HSIZE_WORD) begin
                  if (addr_r[7:0] == ABR_OFS_WAIT_LOW)
                     wait_low_nxt = pwdata_r;
                  if (addr_r[7:0] == ABR_OFS_WAIT_HIGH)
                     wait_high_nxt = pwdata_r;
               end
               state_nxt = ABR_IDLE;
            end else begin
               cnt_nxt = cnt_r + 2'h1;
            end
         end
         default: state_nxt = ABR_IDLE;
      endcase
   end

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         state_r <= ABR_IDLE;
         addr_r <= 32'h0;
         wr_r <= 1'b0;
         size_r <= 2'h0;
         wait_r <= 2'h0;
         cnt_r <= 2'h0;
         wait_low_r <= ABR_RST_WAIT_LOW;
         wait_high_r <= ABR_RST_WAIT_HIGH;
         rdata_r <= 32'h0;
         pwdata_r <= 32'h0;
      end else begin
         state_r <= state_nxt;
         addr_r <= addr_nxt;
         wr_r <= wr_nxt;
         size_r <= size_nxt;
         wait_r <= wait_nxt;
         cnt_r <= cnt_nxt;
         wait_low_r <= wait_low_nxt;
         wait_high_r <= wait_high_nxt;
         rdata_r <= rdata_nxt;
         pwdata_r <= pwdata_nxt;
      end
   end

   // ***********************
   // outputs
   // ***********************
   logic active;
   assign active = (state_r != ABR_IDLE);
   // ready low from the accepting edge until the completing one
   assign hready_out = !active;
   assign hresp = 2'h0;
   assign hrdata = rdata_r;
   assign penable = (state_r == ABR_ACCESS);
   assign pwrite = wr_r;
   assign paddr = addr_r;
   assign pwdata = pwdata_r;

   always_comb begin
      psel = '0;
      if (active && !self_sel)
         psel[cur_slot] = 1'b1;
   end

   // ***********************
   // checks
   // ***********************
   // cycles since acceptance; feeds the length checks only
   logic [2:0] low_cnt_r, low_cnt_nxt;

   always_comb begin
      low_cnt_nxt = 3'h0;
      if (active && state_nxt != ABR_IDLE)
         low_cnt_nxt = low_cnt_r + 3'h1;
   end

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         low_cnt_r <= 3'h0;
      end else begin
         low_cnt_r <= low_cnt_nxt;
      end
   end

   a_psel_onehot: assert property (
      @(posedge clock) disable iff (!nrst) $onehot0(psel))
      else $error("more than one select");
   a_idle_quiet: assert property (
      @(posedge clock) disable iff (!nrst)
      !active |-> (!penable && psel == '0))
      else $error("bus driven while idle");
   a_target_sel: assert property (
      @(posedge clock) disable iff (!nrst)
      (active && !self_sel) |-> psel[cur_slot])
      else $error("target slot not selected");
   a_self_quiet: assert property (
      @(posedge clock) disable iff (!nrst)
      (active && self_sel) |-> (psel == '0))
      else $error("select driven for own registers");
   a_min_length: assert property (
      @(posedge clock) disable iff (!nrst)
      (state_r == ABR_IDLE && start) |=> !hready_out [*2])
      else $error("access shorter than two cycles");
   a_setup_first: assert property (
      @(posedge clock) disable iff (!nrst)
      (state_r == ABR_SETUP) |-> !penable ##1 penable)
      else $error("setup not followed by access");
   a_access_held: assert property (
      @(posedge clock) disable iff (!nrst)
      (state_r == ABR_ACCESS) |-> $stable(paddr) && $stable(psel)
      && $stable(pwrite))
      else $error("address phase changed in access");
   a_wait_len: assert property (
      @(posedge clock) disable iff (!nrst)
      (state_r == ABR_SETUP && wait_r == 2'h3) |-> !hready_out [*5]
      ##1 hready_out)
      else $error("three waits wrong length");
   a_zero_wait: assert property (
      @(posedge clock) disable iff (!nrst)
      (state_r == ABR_SETUP && wait_r == 2'h0) |=> ##1 hready_out)
      else $error("zero wait wrong length");
   a_exact_len: assert property (
      @(posedge clock) disable iff (!nrst)
      (state_r == ABR_ACCESS && state_nxt == ABR_IDLE)
      |-> (low_cnt_r == {1'b0, wait_r} + 3'h1))
      else $error("access length differs from wait field");
   a_ready_bound: assert property (
      @(posedge clock) disable iff (!nrst)
      active |-> (low_cnt_r <= 3'h4))
      else $error("ready held low too long");
   a_cnt_bound: assert property (
      @(posedge clock) disable iff (!nrst)
      (state_r == ABR_ACCESS) |-> (cnt_r <= wait_r))
      else $error("wait counter ran past its field");
   a_wait_stable: assert property (
      @(posedge clock) disable iff (!nrst)
      (active && state_nxt != ABR_IDLE && state_r != ABR_IDLE)
      |=> $stable(wait_r)) else $error("wait changed mid access");
   a_field_latch: assert property (
      @(posedge clock) disable iff (!nrst)
      (state_r == ABR_IDLE && start)
      |=> (wait_r == $past(slot_wait_field)))
      else $error("wait field not taken at acceptance");
   a_ready_done: assert property (
      @(posedge clock) disable iff (!nrst)
      $rose(hready_out) |-> $past(state_r) == ABR_ACCESS)
      else $error("ready without completion");
   a_read_return: assert property (
      @(posedge clock) disable iff (!nrst)
      (state_r == ABR_ACCESS && state_nxt == ABR_IDLE && !wr_r)
      |=> (hrdata == $past(lane_rdata)))
      else $error("read data not returned at completion");
   a_low_write: assert property (
      @(posedge clock) disable iff (!nrst)
      (state_r == ABR_ACCESS && state_nxt == ABR_IDLE && wr_r && self_sel
      && size_r == ABR_HSIZE_WORD && addr_r[7:0] == ABR_OFS_WAIT_LOW)
      |=> (wait_low_r == $past(pwdata_r)))
      else $error("low wait register not written");
   a_high_write: assert property (
      @(posedge clock) disable iff (!nrst)
      (state_r == ABR_ACCESS && state_nxt == ABR_IDLE && wr_r && self_sel
      && size_r == ABR_HSIZE_WORD && addr_r[7:0] == ABR_OFS_WAIT_HIGH)
      |=> (wait_high_r == $past(pwdata_r)))
      else $error("high wait register not written");
   a_narrow_own: assert property (
      @(posedge clock) disable iff (!nrst)
      (active && self_sel && size_r != ABR_HSIZE_WORD)
      |=> $stable(wait_low_r) && $stable(wait_high_r))
      else $error("narrow write changed a wait register");
   a_byte_strobe: assert property (
      @(posedge clock) disable iff (!nrst)
      (active && size_r == ABR_HSIZE_BYTE) |->
      (upper_byte_active != lower_byte_active))
      else $error("byte strobes wrong");
   a_wide_strobe: assert property (
      @(posedge clock) disable iff (!nrst)
      (active && size_r != ABR_HSIZE_BYTE) |->
      (upper_byte_active && lower_byte_active))
      else $error("wide access missing a lane strobe");
   a_byte_lane: assert property (
      @(posedge clock) disable iff (!nrst)
      (penable && size_r == ABR_HSIZE_BYTE) |-> (pwdata[31:8] == 24'h0))
      else $error("byte write data outside low lane");
   c_write: cover property (@(posedge clock) active && wr_r && penable);
   c_read: cover property (@(posedge clock) active && !wr_r && penable);
   c_self: cover property (@(posedge clock) active && self_sel && wr_r);
   c_max_wait: cover property (@(posedge clock) penable && wait_r == 2'h3);
   c_byte: cover property (@(posedge clock) penable && size_r == ABR_HSIZE_BYTE);
endmodule

// File: abr_apb_model.sv
`timescale 1ns/1ps
// ***********************
// peripheral side of the bridge
// ***********************
module abr_apb_model(
   input wire logic clock,
   input wire logic nrst,
   input wire logic [31:0] psel,
   input wire logic [31:0] paddr,
   output logic [31:0] prdata
);
   logic [31:0] junk_r;
   // unselected bus floats: changing junk, never the last read value
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         junk_r <= 32'h0;
      end else begin
         junk_r <= ~junk_r ^ 32'h1;
      end
   end
   // answers from plain apb signals only, no ahb view
   assign prdata = (|psel) ? (paddr ^ 32'h5a5a_c3c3) : junk_r;
endmodule

// File: testbench.sv
`timescale 1ns/1ps
module testbench;
   typedef struct packed {
      logic w;
      logic [31:0] a;
      logic [2:0] sz;
      logic [31:0] wd;
      logic [3:0] cy;
   } abr_row_t;
   logic clock = 1'b0;
   logic nrst = 1'b0;
   logic hsel = 1'b0, hwrite = 1'b0;
   logic [1:0] htrans = 2'h0;
   logic [2:0] hsize = 3'h0;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0;
   logic [31:0] prdata, hrdata, paddr, pwdata, psel;
   logic hready_out, penable, pwrite, ub, lb;
   logic [1:0] hresp;
   logic hrdy_in = 1'b1;
   logic [31:0] lo = 32'h0040_0500, hi = 32'h0, rd_s, psel_s, pwd_s, pad_s;
   logic ub_s, lb_s, pw_s;
   int cyc, pen_n, miscompares = 0, checks_done = 0;
   // last column: expected access length in cycles
   abr_row_t rows[8] = '{
      '{1'b1, 32'h2000, 3'h2, 32'h1122_3344, 4'h2},
      '{1'b0, 32'h2010, 3'h2, 32'h0, 4'h2},
      '{1'b1, 32'ha002, 3'h1, 32'hbeef_cafe, 4'h3},
      '{1'b0, 32'ha000, 3'h1, 32'h0, 4'h3},
      '{1'b0, 32'h1_0000, 3'h2, 32'h0, 4'h5},
      '{1'b1, 32'h1_1000, 3'h2, 32'h5555_aaaa, 4'h4},
      '{1'b0, 32'h1_2000, 3'h2, 32'h0, 4'h3},
      '{1'b0, 32'h1_f004, 3'h2, 32'h0, 4'h2}};
   always #50 clock = ~clock;
   abr_bridge u_dut(.clock(clock), .nrst(nrst), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready_in(hrdy_in), .hready_out(hready_out), .hresp(hresp),
      .hrdata(hrdata), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .upper_byte_active(ub), .lower_byte_active(lb));
   abr_apb_model u_apb(.clock(clock), .nrst(nrst), .psel(psel),
      .paddr(paddr), .prdata(prdata));
   task results;
      if (miscompares == 0 && checks_done > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checks_done++;
      if (g !== e) begin
         miscompares++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask
   // entered just after an edge with the bridge idle
   task xfer(input logic w, input logic [31:0] a, input logic [2:0] sz,
         input logic [31:0] wd);
      hsel = 1'b1;
      htrans = 2'h2;
      hwrite = w;
      haddr = a;
      hsize = sz;
      @(posedge clock);
      #1;
      hsel = 1'b0;
      htrans = 2'h0;
      hwdata = wd;
      cyc = 0;
      pen_n = 0;
      psel_s = 32'h0;
      while (hready_out !== 1'b1) begin
         if (|psel) begin
            psel_s = psel;
            pwd_s = pwdata;
            pad_s = paddr;
            pw_s = pwrite;
            ub_s = ub;
            lb_s = lb;
            if (penable === 1'b1)
               pen_n++;
         end
         @(posedge clock);
         #1;
         cyc++;
         if (cyc > 20) begin
            miscompares++;
            results();
         end
      end
      rd_s = hrdata;
   endtask
   task row_chk(input abr_row_t r);
      logic [4:0] s;
      logic [1:0] wt;
      logic [1:0] st;
      logic [31:0] m, f, rx;
      s = r.a[16:12];
      wt = s[4] ? hi[{s[3:0], 1'b0} +: 2] : lo[{s[3:0], 1'b0} +: 2];
      m = (r.sz == 3'h0) ? 32'hff : (r.sz == 3'h1) ? 32'hffff : 32'hffff_ffff;
      f = r.a ^ 32'h5a5a_c3c3;
      st = (r.sz == 3'h0) ? {r.a[0], ~r.a[0]} : 2'b11;
      rx = (r.sz == 3'h0) ? {4{f[7:0]}} : (r.sz == 3'h1) ? {2{f[15:0]}} : f;
      xfer(r.w, r.a, r.sz, r.wd);
      chk("cycles", 32'(r.cy), cyc);
      chk("wait field", 32'(2 + wt), cyc);
      chk("enable cycles", 32'(1 + wt), pen_n);
      chk("select", 32'h1 << s, psel_s);
      chk("address", r.a, pad_s);
      chk("direction", 32'(r.w), 32'(pw_s));
      chk("response", 32'h0, 32'(hresp));
      chk("strobes", 32'(st), 32'({ub_s, lb_s}));
      if (r.w)
         chk("wdata", (r.wd >> {r.a[1:0], 3'h0}) & m, pwd_s);
      else
         chk("rdata", rx, rd_s);
   endtask
   initial begin
      repeat (8) @(posedge clock);
      #1 nrst = 1'b1;
      xfer(1'b0, 32'h0, 3'h2, 32'h0);
      chk("wait low", 32'h0040_0500, rd_s);
      xfer(1'b0, 32'h4, 3'h2, 32'h0);
      chk("wait high", 32'h0, rd_s);
      lo = 32'h0050_0500;
      hi = 32'h1b1b_1b1b;
      xfer(1'b1, 32'h0, 3'h2, lo);
      chk("own cycles", 32'h2, cyc);
      xfer(1'b1, 32'h4, 3'h2, hi);
      xfer(1'b0, 32'h0, 3'h2, 32'h0);
      chk("wait low", lo, rd_s);
      xfer(1'b0, 32'h4, 3'h2, 32'h0);
      chk("wait high", hi, rd_s);
      xfer(1'b0, 32'h8, 3'h2, 32'h0);
      chk("unmapped", 32'h0, rd_s);
      // own registers take word writes only
      xfer(1'b1, 32'h0, 3'h0, 32'hffff_ffff);
      xfer(1'b0, 32'h0, 3'h2, 32'h0);
      chk("narrow own write", lo, rd_s);
      foreach (rows[i]) row_chk(rows[i]);
      for (int i = 0; i < 4; i++) begin
         row_chk('{1'b1, 32'h4000 + i, 3'h0, 32'h8796_a5b4, 4'h3});
         row_chk('{1'b0, 32'h5000 + i, 3'h0, 32'h0, 4'h3});
      end
      // second reset in mid-run must restore the defaults
      nrst = 1'b0;
      @(posedge clock);
      #1;
      chk("ready in reset", 32'h1, 32'(hready_out));
      chk("select in reset", 32'h0, psel);
      nrst = 1'b1;
      xfer(1'b0, 32'h0, 3'h2, 32'h0);
      chk("wait low", 32'h0040_0500, rd_s);
      // a request while the bus is not ready must not be taken
      hrdy_in = 1'b0;
      hsel = 1'b1;
      htrans = 2'h2;
      @(posedge clock);
      #1;
      chk("ready held off", 32'h1, 32'(hready_out));
      chk("select held off", 32'h0, psel);
      hsel = 1'b0;
      htrans = 2'h0;
      hrdy_in = 1'b1;
      results();
   end
endmodule
